// [companion_defs.svh]
// Purpose: constants for the two-wire memory and companion access block
// Assumes: included by the design modules, the checker and the bench
// Notes:   bare numbers of the logic are named here
`ifndef COMPANION_DEFS_SVH
`define COMPANION_DEFS_SVH
`define MEM_ID          4'h5
`define REG_ID          4'h9
`define REG_ADDR_MAX    8'h18
`define MEM_AW          15
`define MEM_TOP         15'h7fff
`define MEM_ZERO        15'h0000
`define REG_ZERO        8'h00
`define BIT_LAST        3'h7
`define BIT_ZERO        3'h0
`define BYTE_ZERO       8'h00
`define DENS_256K       2'h3
`define DENS_64K        2'h2
`define DENS_16K        2'h1
`define DENS_4K         2'h0
`define MASK_256K       15'h7fff
`define MASK_64K        15'h1fff
`define MASK_16K        15'h07ff
`define MASK_4K         15'h01ff
`endif

// [companion_pkg.sv]
// Purpose: shared types for the two-wire access block
// Assumes: companion_defs.svh holds the numbers
// Notes:   state of the main module is one packed struct
package companion_pkg;
  // protocol phases
  typedef enum logic [3:0] {
    ST_IDLE, ST_SLAVE, ST_SLAVE_ACK, ST_ADDR_HI, ST_ADDR_LO, ST_ADDR_ACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_IGNORE
  } phase_t;
  // bus conditions seen on the synchronised lines
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } bus_evt_t;
  // memory access request toward the array
  typedef struct packed {
    logic        we;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;
  // full state of the protocol engine
  typedef struct packed {
    phase_t      phase;
    logic [2:0]  bitcnt;
    logic        got8;     // a full byte came in, ack slot next
    logic [7:0]  shift;
    logic        is_reg;
    logic        is_read;
    logic        hi_phase;
    logic        addr_ok;
    logic [14:0] mem_ptr;
    logic [7:0]  reg_ptr;
    logic [7:0]  hi_byte;
    logic        sda_oe;
    logic        mem_we;
    logic        reg_we;
    logic [14:0] wr_addr;
    logic [7:0]  wr_data;
  } eng_t;
endpackage

// [bus_sampler.sv]
// Purpose: two-stage synchroniser and condition detector for scl and sda
// Assumes: one clock, active low asynchronous reset
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`include "companion_defs.svh"
module bus_sampler (
  input  wire logic                 clk_sys_in,
  input  wire logic                 resetn_in,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output companion_pkg::bus_evt_t   evt_out
);
  // ==========================================================
  // synchroniser and history
  logic [1:0] scl_meta_r;   // scl stages
  logic [1:0] sda_meta_r;   // sda stages
  logic       scl_old_r;    // previous synced scl
  logic       sda_old_r;    // previous synced sda
  // sample lines, bus idles high
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_meta_r <= 2'h3;
      sda_meta_r <= 2'h3;
      scl_old_r  <= 1'h1;
      sda_old_r  <= 1'h1;
    end else begin
      scl_meta_r <= {scl_meta_r[0], scl_in};
      sda_meta_r <= {sda_meta_r[0], sda_in};
      scl_old_r  <= scl_meta_r[1];
      sda_old_r  <= sda_meta_r[1];
    end
  end
  // ==========================================================
  // condition detection from synced samples
  always_comb begin
    evt_out.scl_rise = scl_meta_r[1] & ~scl_old_r;
    evt_out.scl_fall = ~scl_meta_r[1] & scl_old_r;
    evt_out.start = scl_meta_r[1] & scl_old_r
                    & sda_old_r & ~sda_meta_r[1];
    evt_out.stop  = scl_meta_r[1] & scl_old_r
                    & ~sda_old_r & sda_meta_r[1];
    evt_out.sda   = sda_meta_r[1];
  end
endmodule

// [companion_access.sv]
// Purpose: two-wire slave access to memory array and companion registers
// Assumes: scl and sda asynchronous inputs, 10 MHz system clock
// Notes:   memory and register file are arrays held here
//          events reach the engine three clocks after the pins move,
//          so scl must stay high and low for at least four clocks
`timescale 1ns/1ps
`include "companion_defs.svh"
module companion_access (
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [1:0] sel_pins_in,
  input  wire logic [1:0] density_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            mem_we_out,
  output logic            reg_we_out,
  output logic [14:0]     wr_addr_out,
  output logic [7:0]      wr_data_out,
  output logic [14:0]     mem_ptr_out,
  output logic [7:0]      reg_ptr_out
);
  // ==========================================================
  // storage and state
  // the two pointers live in the state struct and never share
  // an adder, so traffic to one target leaves the other alone
  logic [7:0] mem_q [0:32767];           // memory array
  logic [7:0] reg_q [0:24];              // companion registers
  companion_pkg::eng_t     st_r;         // registered state
  companion_pkg::eng_t     st_nxt;       // next state
  companion_pkg::bus_evt_t evt;          // synced bus events
  logic [14:0]             dmask;        // density address mask
  logic [7:0]              rd_byte;      // byte to transmit
  logic [7:0]              inb;          // byte just completed
  logic                    sda_q_r;      // registered sda level

  // ==========================================================
  // line sampler
  // scl and sda pass two flops before any condition is decoded
  bus_sampler u_sampler (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .evt_out    (evt)
  );

  // ==========================================================
  // density mask for memory addresses
  // bits above the array are dropped at load and at every step,
  // so the pointer never leaves the fitted array
  always_comb begin
    case (density_in)
      `DENS_256K: dmask = `MASK_256K;
      `DENS_64K:  dmask = `MASK_64K;
      `DENS_16K:  dmask = `MASK_16K;
      default:    dmask = `MASK_4K;
    endcase
  end

  // read data source picks the pointer of the selected target
  // register addresses past the last one read back as zero; the
  // pointer wraps before that, the guard only keeps the index safe
  always_comb begin
    if (st_r.is_reg) begin
      rd_byte = (st_r.reg_ptr <= `REG_ADDR_MAX) ?
                reg_q[st_r.reg_ptr[4:0]] : `BYTE_ZERO;
    end else begin
      rd_byte = mem_q[st_r.mem_ptr];
    end
  end

  // ==========================================================
  // protocol engine
  // start and stop win over scl edges; receiving phases count on
  // scl rises, every change of the driven data waits for a fall,
  // so the device never moves sda while scl is high
  always_comb begin
    st_nxt        = st_r;
    st_nxt.mem_we = 1'h0;
    st_nxt.reg_we = 1'h0;
    inb           = {st_r.shift[6:0], evt.sda};
    if (evt.start) begin
      // start aborts anything, also restarts after write address
      st_nxt.phase  = companion_pkg::ST_SLAVE;
      st_nxt.bitcnt = `BIT_ZERO;
      // the scl fall that closes the start is not an ack slot
      st_nxt.got8   = 1'h0;
      st_nxt.sda_oe = 1'h0;
    end else if (evt.stop) begin
      // stop releases bus and ends any operation
      st_nxt.phase  = companion_pkg::ST_IDLE;
      st_nxt.sda_oe = 1'h0;
    end else if (evt.scl_rise) begin
      case (st_r.phase)
        // receiving phases shift in a bit
        companion_pkg::ST_SLAVE, companion_pkg::ST_ADDR_HI,
        companion_pkg::ST_ADDR_LO, companion_pkg::ST_WDATA: begin
          st_nxt.shift  = inb;
          st_nxt.bitcnt = st_r.bitcnt + 3'h1;
          if (st_r.bitcnt == `BIT_LAST) begin
            // eighth bit in: the next fall opens the ack slot
            st_nxt.got8 = 1'h1;
            case (st_r.phase)
              companion_pkg::ST_SLAVE: begin
                st_nxt.is_reg  = (inb[7:4] == `REG_ID);
                st_nxt.is_read = inb[0];
                st_nxt.addr_ok = ((inb[7:4] == `REG_ID) ||
                                  (inb[7:4] == `MEM_ID)) &&
                                 (inb[2:1] == sel_pins_in);
              end
              companion_pkg::ST_ADDR_HI: begin
                st_nxt.hi_byte = inb;
                st_nxt.addr_ok = 1'h1;
              end
              companion_pkg::ST_ADDR_LO: begin
                if (st_r.is_reg) begin
                  st_nxt.addr_ok = (inb <= `REG_ADDR_MAX);
                  if (inb <= `REG_ADDR_MAX) begin
                    st_nxt.reg_ptr = inb;
                  end
                end else begin
                  st_nxt.addr_ok = 1'h1;
                  st_nxt.mem_ptr = {st_r.hi_byte[6:0], inb}
                                   & dmask;
                end
              end
              default: begin
                // data byte write issued at the old pointer, pointer advances in the same clock
                st_nxt.addr_ok = 1'h1;
                if (st_r.is_reg) begin
                  st_nxt.reg_we  = 1'h1;
                  st_nxt.wr_addr = {7'h00, st_r.reg_ptr};
                  st_nxt.reg_ptr = (st_r.reg_ptr == `REG_ADDR_MAX) ?
                                   `REG_ZERO :
                                   st_r.reg_ptr + 8'h01;
                end else begin
                  st_nxt.mem_we  = 1'h1;
                  st_nxt.wr_addr = st_r.mem_ptr;
                  st_nxt.mem_ptr = (st_r.mem_ptr + 15'h0001)
                                   & dmask;
                end
                st_nxt.wr_data = inb;
              end
            endcase
            st_nxt.hi_phase = (st_r.phase == companion_pkg::ST_ADDR_HI);
          end
        end
        // ack bit sampled from master after a sent byte
        companion_pkg::ST_RACK: begin
          if (evt.sda) begin
            st_nxt.phase = companion_pkg::ST_IGNORE;
          end else begin
            // acked: the next byte leaves on the coming fall, just as
            // after the slave address, from the advanced pointer
            st_nxt.phase = companion_pkg::ST_SLAVE_ACK;
          end
        end
        default: begin
        end
      endcase
    end else if (evt.scl_fall) begin
      case (st_r.phase)
        companion_pkg::ST_SLAVE, companion_pkg::ST_ADDR_HI,
        companion_pkg::ST_ADDR_LO, companion_pkg::ST_WDATA: begin
          // after the eighth bit drive ack or give up; a fall with
          // no byte behind it (end of start) changes nothing
          if (st_r.got8) begin
            st_nxt.got8 = 1'h0;
            if (st_r.addr_ok) begin
              st_nxt.sda_oe = 1'h1;
              st_nxt.shift  = `BYTE_ZERO;
              case (st_r.phase)
                companion_pkg::ST_SLAVE:
                  st_nxt.phase = companion_pkg::ST_SLAVE_ACK;
                companion_pkg::ST_WDATA:
                  st_nxt.phase = companion_pkg::ST_WACK;
                default:
                  st_nxt.phase = companion_pkg::ST_ADDR_ACK;
              endcase
            end else begin
              st_nxt.phase = companion_pkg::ST_IGNORE;
            end
          end
        end
        companion_pkg::ST_SLAVE_ACK: begin
          st_nxt.bitcnt = `BIT_ZERO;
          if (st_r.is_read) begin
            // first data bit goes out on this falling edge, also
            // for every byte after an acked one
            st_nxt.phase  = companion_pkg::ST_RDATA;
            st_nxt.shift  = rd_byte;
            st_nxt.sda_oe = ~rd_byte[7];
          end else begin
            // write always starts with an address
            st_nxt.sda_oe = 1'h0;
            st_nxt.phase  = st_r.is_reg ? companion_pkg::ST_ADDR_LO :
                            companion_pkg::ST_ADDR_HI;
          end
        end
        companion_pkg::ST_ADDR_ACK: begin
          st_nxt.sda_oe = 1'h0;
          st_nxt.bitcnt = `BIT_ZERO;
          st_nxt.phase  = st_r.hi_phase ? companion_pkg::ST_ADDR_LO :
                          companion_pkg::ST_WDATA;
        end
        companion_pkg::ST_WACK: begin
          st_nxt.sda_oe = 1'h0;
          st_nxt.bitcnt = `BIT_ZERO;
          st_nxt.phase  = companion_pkg::ST_WDATA;
        end
        companion_pkg::ST_RDATA: begin
          if (st_r.bitcnt == `BIT_LAST) begin
            // byte sent: release for ack and advance pointer
            st_nxt.sda_oe = 1'h0;
            st_nxt.phase  = companion_pkg::ST_RACK;
            st_nxt.bitcnt = `BIT_ZERO;
            if (st_r.is_reg) begin
              st_nxt.reg_ptr = (st_r.reg_ptr == `REG_ADDR_MAX) ?
                               `REG_ZERO :
                               st_r.reg_ptr + 8'h01;
            end else begin
              st_nxt.mem_ptr = (st_r.mem_ptr + 15'h0001)
                               & dmask;
            end
          end else begin
            st_nxt.shift  = {st_r.shift[6:0], 1'h0};
            st_nxt.sda_oe = ~st_r.shift[6];
            st_nxt.bitcnt = st_r.bitcnt + 3'h1;
          end
        end
        default: begin
        end
      endcase
    end
    // read timing: every data bit changes only on a seen scl fall,
    // about three clocks after the pin, so sda is settled long before
    // the master raises scl again; a byte is loaded from the target
    // at the fall that ends the ack slot, never earlier, so the
    // pointer advanced at the end of the previous byte is used;
    // a master that acks and then stops or restarts in the ninth
    // clock is caught before that fall and nothing is driven
  end

  // ==========================================================
  // state register and storage writes
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r         <= '0;
      st_r.phase   <= companion_pkg::ST_IDLE;
      st_r.mem_ptr <= `MEM_ZERO;
      st_r.reg_ptr <= `REG_ZERO;
      sda_q_r      <= 1'h1;
    end else begin
      st_r <= st_nxt;
      // open drain: the data pin level is high in reset and low after it, only the
      // enable says whether the device pulls the line
      sda_q_r <= 1'h0;
    end
  end

  // array writes, memory untouched by register traffic
  // writes land one clock after the enable pulse is registered;
  // reads are combinational from the pointer, so no stale byte
  always_ff @(posedge clk_sys_in) begin
    if (st_r.mem_we) begin
      mem_q[st_r.wr_addr] <= st_r.wr_data;
    end
    if (st_r.reg_we) begin
      reg_q[st_r.wr_addr[4:0]] <= st_r.wr_data;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  // no logic between the registers and the pins, so every output
  // is free of glitches and settles one clock after its event
  always_comb begin
    sda_out     = sda_q_r;
    sda_oe_out  = st_r.sda_oe;
    mem_we_out  = st_r.mem_we;
    reg_we_out  = st_r.reg_we;
    wr_addr_out = st_r.wr_addr;
    wr_data_out = st_r.wr_data;
    mem_ptr_out = st_r.mem_ptr;
    reg_ptr_out = st_r.reg_ptr;
  end
endmodule

// [companion_access_asserts.sv]
// Purpose: port checks for the two-wire access block
// Assumes: one clock domain, scl levels held >= 6 system clocks
// Notes:   windows allow for the three clock input latency
`timescale 1ns/1ps
`include "companion_defs.svh"
module companion_access_asserts (
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic [1:0]  sel_pins_in,
  input wire logic [1:0]  density_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  input wire logic        mem_we_out,
  input wire logic        reg_we_out,
  input wire logic [14:0] wr_addr_out,
  input wire logic [7:0]  wr_data_out,
  input wire logic [14:0] mem_ptr_out,
  input wire logic [7:0]  reg_ptr_out
);
  // ==========================================================
  // address mask
  logic [14:0] mask;  // valid memory bits for this density
  // density decode
  always_comb begin
    case (density_in)
      `DENS_256K: mask = `MASK_256K;
      `DENS_64K:  mask = `MASK_64K;
      `DENS_16K:  mask = `MASK_16K;
      default:    mask = `MASK_4K;
    endcase
  end
  // ==========================================================
  // properties
  default clocking dcb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  AST_MEM_PTR_STEP:
    assert property (mem_we_out |-> ##[0:2]
      mem_ptr_out == ((wr_addr_out + 15'h0001) & mask))
    else $error("memory pointer did not step after write");
  AST_REG_PTR_STEP:
    assert property (reg_we_out |-> ##[0:2] reg_ptr_out ==
      (wr_addr_out[7:0] == `REG_ADDR_MAX ? `REG_ZERO
                                         : wr_addr_out[7:0] + 8'h01))
    else $error("register pointer did not step after write");
  AST_REG_WR_RANGE:
    assert property (reg_we_out |-> wr_addr_out[7:0] <= `REG_ADDR_MAX)
    else $error("register write beyond last register");
  AST_MEM_WR_MASK:
    assert property (mem_we_out |-> (wr_addr_out & ~mask) == 15'h0000)
    else $error("memory write address not masked");
  AST_PTRS_APART:
    assert property ($changed(reg_ptr_out) |-> $stable(mem_ptr_out))
    else $error("memory pointer moved with register pointer");
  AST_OE_RISE_LOW:
    assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("sda driven while scl high");
  AST_OE_STEADY:
    assert property ($rose(scl_in) |=> $stable(sda_oe_out)[*4])
    else $error("sda changed during scl high");
  AST_STOP_RELEASE:
    assert property (scl_in && $past(scl_in) && $rose(sda_in)
      |-> ##[1:6] (!sda_oe_out)[*3])
    else $error("sda not released after stop");
  AST_SDA_OPEN_DRAIN:
    assert property (sda_oe_out |-> !sda_out)
    else $error("data pin driven high");
  // main scenarios
  cover property (mem_we_out);
  cover property (reg_we_out);
  cover property ($fell(sda_oe_out) && scl_in);
endmodule
bind companion_access companion_access_asserts i_companion_access_asserts (
  .clk_sys_in, .resetn_in, .scl_in, .sda_in, .sel_pins_in, .density_in,
  .sda_out, .sda_oe_out, .mem_we_out, .reg_we_out, .wr_addr_out,
  .wr_data_out, .mem_ptr_out, .reg_ptr_out
);

// [host_master.sv]
// Purpose: behavioural two-wire bus master facing the access block
// Assumes: lines change on the falling system clock edge
// Notes:   sda is open drain with pull-up, resolved here
`timescale 1ns/1ps
module host_master #(
  parameter int HALF = 6
) (
  input  wire logic clk_in,
  input  wire logic dev_sda_in,
  input  wire logic dev_oe_in,
  output logic      scl_out,
  output logic      sda_out
);
  // ==========================================================
  // wire resolution
  logic drv;  // master level, 1 = released
  assign sda_out = drv & ~(dev_oe_in & ~dev_sda_in);
  // idle bus at time zero
  initial begin
    drv = 1'b1;
    scl_out = 1'b1;
  end
  // half bit period
  task automatic hp();
    repeat (HALF) @(negedge clk_in);
  endtask
  // start or repeated start, also in ninth or tenth clock
  task automatic start();
    drv = 1'b1;
    hp();
    scl_out = 1'b1;
    hp();
    drv = 1'b0;
    hp();
    scl_out = 1'b0;
    @(negedge clk_in);
  endtask
  // stop, also in ninth or tenth clock
  task automatic stop();
    drv = 1'b0;
    hp();
    scl_out = 1'b1;
    hp();
    drv = 1'b1;
    hp();
  endtask
  // one bit, sampled at the end of scl high, sda held a clock
  task automatic clk_bit(input logic b, output logic seen);
    drv = b;
    hp();
    scl_out = 1'b1;
    hp();
    seen = sda_out;
    scl_out = 1'b0;
    @(negedge clk_in);
  endtask
  // byte out msb first, ack sampled in the ninth clock
  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  // eight bits in, ninth clock left to caller
  task automatic rx8(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
  endtask
  // ninth clock: ack continues, nack ends
  task automatic ack9(input logic a);
    logic s;
    clk_bit(~a, s);
  endtask
endmodule

// [two_wire_memory_companion_access_test.sv]
// Purpose: self-checking bench for the two-wire access block
// Assumes: host_master drives the bus, checker bound to the block
// Notes:   select pins strapped except in t_refuse, density set at reset and moved only in t_wrap
`timescale 1ns/1ps
`include "companion_defs.svh"
module two_wire_memory_companion_access_test;
  localparam logic [1:0] SEL = 2'b10;  // select strap
  localparam logic [7:0] MW = {`MEM_ID, 1'b0, SEL, 1'b0};  // mem write
  localparam logic [7:0] MR = MW | 8'h01;  // mem read
  localparam logic [7:0] RW = {`REG_ID, 1'b0, SEL, 1'b0};  // reg write
  localparam logic [7:0] RR = RW | 8'h01;  // reg read
  logic        clk = 1'b0;  // 10 MHz system clock
  logic        resetn;  // active low reset
  logic [1:0]  density;  // array size select
  logic [1:0]  sel = SEL;  // select pins, moved in t_refuse
  logic        scl, sda, dev_sda, oe, mwe, rwe;
  logic [14:0] wr_addr, mem_ptr;
  logic [7:0]  wr_data, reg_ptr;
  int          error_cnt = 0;
  int          n_tests = 0;
  always #50 clk = ~clk;
  companion_access i_companion_access (
    .clk_sys_in(clk), .resetn_in(resetn), .scl_in(scl), .sda_in(sda),
    .sel_pins_in(sel), .density_in(density), .sda_out(dev_sda),
    .sda_oe_out(oe), .mem_we_out(mwe), .reg_we_out(rwe),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data),
    .mem_ptr_out(mem_ptr), .reg_ptr_out(reg_ptr)
  );
  host_master i_host_master (
    .clk_in(clk), .dev_sda_in(dev_sda), .dev_oe_in(oe),
    .scl_out(scl), .sda_out(sda)
  );
  // ==========================================================
  // helpers
  task automatic chk(input logic [14:0] seen, input logic [14:0] exp,
                     input string w);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, w, seen, exp);
    end
  endtask
  task automatic st();
    i_host_master.start();
  endtask
  task automatic sp();
    i_host_master.stop();
  endtask
  // byte out, compare ack
  task automatic xb(input logic [7:0] b, input logic ea);
    logic a;
    i_host_master.tx(b, a);
    chk({14'h0, a}, {14'h0, ea}, "ack");
  endtask
  // byte in, compare data
  task automatic rb(input logic [7:0] e, input string w);
    logic [7:0] v;
    i_host_master.rx8(v);
    chk({7'h0, v}, {7'h0, e}, w);
  endtask
  // ==========================================================
  // scenarios
  // start, memory write slave address, two address bytes
  task automatic la(input logic [7:0] hi, input logic [7:0] lo);
    st();
    xb(MW, 1'b1);
    xb(hi, 1'b1);
    xb(lo, 1'b1);
  endtask
  task automatic t_mem_select();
    la(8'h12, 8'h34);
    xb(8'ha5, 1'b1);
    xb(8'h5a, 1'b1);
    sp();
    chk(mem_ptr, 15'h1236, "ptr after write");
    chk(wr_addr, 15'h1235, "last write addr");
    chk({7'h0, wr_data}, 15'h005a, "last write data");
    la(8'h12, 8'h34);
    st();
    xb(MR, 1'b1);
    rb(8'ha5, "selective byte");
    i_host_master.ack9(1'b0);
    sp();
    chk(mem_ptr, 15'h1235, "ptr after read");
    $display("test mem_select done");
  endtask
  task automatic t_companion();
    st();
    xb(RW, 1'b1);
    xb(8'h17, 1'b1);
    xb(8'h11, 1'b1);
    xb(8'h22, 1'b1);
    sp();
    chk({7'h0, reg_ptr}, 15'h0000, "reg ptr wrap");
    chk(wr_addr, 15'h0018, "reg write addr");
    chk({7'h0, wr_data}, 15'h0022, "reg write data");
    chk(mem_ptr, 15'h1235, "mem ptr kept");
    st();
    xb(RW, 1'b1);
    xb(8'h17, 1'b1);
    st();
    xb(RR, 1'b1);
    rb(8'h11, "reg byte 0");
    i_host_master.ack9(1'b1);
    rb(8'h22, "reg byte 1");
    st();
    xb(MR, 1'b1);
    rb(8'h5a, "resumed byte");
    i_host_master.ack9(1'b0);
    st();
    sp();
    chk(mem_ptr, 15'h1236, "mem ptr after resume");
    chk({7'h0, reg_ptr}, 15'h0000, "reg ptr after read");
    $display("test companion done");
  endtask
  task automatic t_wrap();
    density = `DENS_64K;
    la(8'hff, 8'hff);
    sp();
    chk(mem_ptr, 15'h1fff, "64k mask");
    density = `DENS_16K;
    la(8'hff, 8'hff);
    sp();
    chk(mem_ptr, 15'h07ff, "16k mask");
    density = `DENS_4K;
    la(8'hff, 8'hff);
    xb(8'h3c, 1'b1);
    xb(8'hc3, 1'b1);
    sp();
    chk(mem_ptr, 15'h0001, "wrapped ptr");
    la(8'h01, 8'hff);
    st();
    xb(MR, 1'b1);
    rb(8'h3c, "top byte");
    i_host_master.ack9(1'b1);
    rb(8'hc3, "wrapped byte");
    sp();
    chk(mem_ptr, 15'h0001, "ptr after wrap read");
    $display("test wrap done");
  endtask
  task automatic t_refuse();
    st();
    xb(RW, 1'b1);
    xb(8'h05, 1'b1);
    sp();
    st();
    xb(RW, 1'b1);
    xb(8'h19, 1'b0);
    xb(8'h77, 1'b0);
    sp();
    chk({7'h0, reg_ptr}, 15'h0005, "ptr after refusal");
    st();
    xb({`MEM_ID, 1'b0, ~SEL, 1'b1}, 1'b0);
    sp();
    st();
    xb({`MEM_ID ^ `REG_ID, 1'b0, SEL, 1'b1}, 1'b0);
    sp();
    sel = ~SEL;
    st();
    xb({`MEM_ID, 1'b0, ~SEL, 1'b0}, 1'b1);
    sp();
    sel = SEL;
    $display("test refuse done");
  endtask
  // ==========================================================
  // verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    resetn = 1'b0;
    density = `DENS_256K;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    t_mem_select();
    t_companion();
    t_wrap();
    t_refuse();
    close_out();
  end
  // watchdog, about seven times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule
